// ===== rtl/vcp_defines.svh
// Register map, field positions and reset values of the VCXO PLL bank.
// Assumes inclusion by bare name from the rtl folder.
`ifndef VCP_DEFINES_SVH
`define VCP_DEFINES_SVH

// ----------------------------------------------------------------
// Addresses
// ----------------------------------------------------------------
`define VCP_ADDR_FB       8'h03
`define VCP_ADDR_LOOP     8'h0A
`define VCP_ADDR_POLPUMP  8'h10
`define VCP_ADDR_OUTOFS   8'h11
`define VCP_ADDR_PUMP2    8'h12
`define VCP_ADDR_COMMIT   8'h1F

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VCP_FB_SEL_BIT    0
`define VCP_MV1_MSB_BIT   7
`define VCP_LOOP_BYP_BIT  0
`define VCP_POL_BIT       7
`define VCP_FORCE_BIT     6
`define VCP_POWER_BIT     7
`define VCP_FORMAT_BIT    6
`define VCP_OFS_EN_BIT    5
`define VCP_CODE_MSB      4
`define VCP_AMP_MSB       6
`define VCP_AMP_LSB       5

// ----------------------------------------------------------------
// Reset and startup values
// ----------------------------------------------------------------
`define VCP_FORCE_RST     1'b1
`define VCP_PUMP1_RST     5'h18
`define VCP_PUMP2_RST     5'h18
`define VCP_OFS_RST       5'h00
`define VCP_PWR_STARTUP   1'b1
`define VCP_FMT_STARTUP   1'b1
`define VCP_AMP_STARTUP   2'h3
`define VCP_BYTE_ZERO     8'h00

`endif

// ===== rtl/vcp_pkg.sv
// Types shared by the VCXO PLL control bank modules.
// Assumes nothing beyond a SystemVerilog compiler.
package vcp_pkg;

  // Oscillator output settings that only change on commit
  typedef struct packed {
    logic       power_on;
    logic       format;
    logic [1:0] amplitude;
  } vcp_out_cfg_t;

endpackage

// ===== rtl/vcp_out_if.sv
// Carrier between the register bank and the output staging unit.
// Assumes both modules sit in the same clock domain.
`timescale 1ns/1ps
interface vcp_out_if;
  vcp_pkg::vcp_out_cfg_t staged;
  logic                  commit;
  vcp_pkg::vcp_out_cfg_t active;

  modport bank  (output staged, output commit, input active);
  modport stage (input staged, input commit, output active);
endinterface

// ===== rtl/vcp_out_stage.sv
// Holds the oscillator output settings actually in force.
// Assumes commit is a one-cycle pulse from the register bank.
`timescale 1ns/1ps
`include "vcp_defines.svh"
module vcp_out_stage (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // Bank side
  vcp_out_if.stage  link
);

  vcp_pkg::vcp_out_cfg_t next_active;

  // Startup state differs from the register readback on purpose
  always_comb begin
    next_active = link.active;
    if (link.commit) begin
      next_active = link.staged;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      link.active <= '{power_on:  `VCP_PWR_STARTUP,
                       format:    `VCP_FMT_STARTUP,
                       amplitude: `VCP_AMP_STARTUP};
    end else begin
      link.active <= next_active;
    end
  end

endmodule

// ===== rtl/vcp_ctrl_regs.sv
// Control register bank of the first-stage VCXO PLL and second-stage pump.
// Assumes a serial front end presenting byte reads and writes as strobes.
//
// Behaviour
// - Bit 0 of vcxo_feedback_bypass picks first divider alone or both dividers
// - Bit 0 of vcxo_loop_bypass disables and bypasses the first-stage PLL
// - Bit 7 of vcxo_loop_polarity_pump picks positive or negative tuning polarity
// - Force bit, reset to one, holds tuning at mid-scale
// - First pump code sets 50 uA times code plus one, resets 0x18
// - Oscillator output power bit; output starts powered while reading 0
// - Power change applies only on commit register write
// - Format bit picks LVDS or LVPECL; starts LVPECL while reading 0
// - Format change applies only on commit register write
// - Offset enable applies programmed static phase offset
// - Five-bit offset code, 0.9 degrees per step, resets to zero
// - Second pump code sets 200 uA times code plus one, resets 0x18
`timescale 1ns/1ps
`include "vcp_defines.svh"
module vcp_ctrl_regs (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  // First-stage loop controls
  output logic            feedback_chain_select,
  output logic            second_feedback_divider_msb,
  output logic            first_loop_bypass,
  output logic            tuning_polarity,
  output logic            force_midscale_tune,
  output logic      [4:0] first_pump_current_code,
  output logic            phase_offset_enable,
  output logic      [4:0] phase_offset_code,
  // Second-stage pump
  output logic      [4:0] second_pump_current_code,
  // Oscillator output in force
  output logic            osc_output_power_on,
  output logic            osc_output_format,
  output logic      [1:0] osc_output_amplitude
);

  // ----------------------------------------------------------------
  // Staged register fields
  // ----------------------------------------------------------------
  logic       power_reg;
  logic       format_reg;
  logic [1:0] amp_reg;
  logic       next_fb_sel;
  logic       next_mv1_msb;
  logic       next_loop_byp;
  logic       next_pol;
  logic       next_force;
  logic [4:0] next_pump1;
  logic       next_power;
  logic       next_format;
  logic       next_ofs_en;
  logic [4:0] next_ofs;
  logic [1:0] next_amp;
  logic [4:0] next_pump2;
  logic [7:0] next_rdata;

  vcp_out_if out_link ();

  vcp_out_stage u_stage (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .link     (out_link.stage)
  );

  assign out_link.staged = '{power_on:  power_reg,
                             format:    format_reg,
                             amplitude: amp_reg};
  // Commit takes the staged values as they stand before this edge
  assign out_link.commit = reg_wr && (reg_addr == `VCP_ADDR_COMMIT);
  assign osc_output_power_on  = out_link.active.power_on;
  assign osc_output_format    = out_link.active.format;
  assign osc_output_amplitude = out_link.active.amplitude;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  always_comb begin
    next_fb_sel   = feedback_chain_select;
    next_mv1_msb  = second_feedback_divider_msb;
    next_loop_byp = first_loop_bypass;
    next_pol      = tuning_polarity;
    next_force    = force_midscale_tune;
    next_pump1    = first_pump_current_code;
    next_power    = power_reg;
    next_format   = format_reg;
    next_ofs_en   = phase_offset_enable;
    next_ofs      = phase_offset_code;
    next_amp      = amp_reg;
    next_pump2    = second_pump_current_code;
    if (reg_wr) begin
      unique case (reg_addr)
        `VCP_ADDR_FB: begin
          next_fb_sel  = reg_wdata[`VCP_FB_SEL_BIT];
          next_mv1_msb = reg_wdata[`VCP_MV1_MSB_BIT];
        end
        `VCP_ADDR_LOOP: begin
          next_loop_byp = reg_wdata[`VCP_LOOP_BYP_BIT];
        end
        `VCP_ADDR_POLPUMP: begin
          next_pol   = reg_wdata[`VCP_POL_BIT];
          next_force = reg_wdata[`VCP_FORCE_BIT];
          next_pump1 = reg_wdata[`VCP_CODE_MSB:0];
        end
        `VCP_ADDR_OUTOFS: begin
          // Power and format held back from the pins until the commit write; offset fields apply at once
          next_power  = reg_wdata[`VCP_POWER_BIT];
          next_format = reg_wdata[`VCP_FORMAT_BIT];
          next_ofs_en = reg_wdata[`VCP_OFS_EN_BIT];
          next_ofs    = reg_wdata[`VCP_CODE_MSB:0];
        end
        `VCP_ADDR_PUMP2: begin
          next_amp   = reg_wdata[`VCP_AMP_MSB:`VCP_AMP_LSB];
          next_pump2 = reg_wdata[`VCP_CODE_MSB:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = `VCP_BYTE_ZERO;
    if (reg_rd) begin
      unique case (reg_addr)
        `VCP_ADDR_FB: begin
          next_rdata[`VCP_FB_SEL_BIT]  = feedback_chain_select;
          next_rdata[`VCP_MV1_MSB_BIT] = second_feedback_divider_msb;
        end
        `VCP_ADDR_LOOP: begin
          next_rdata[`VCP_LOOP_BYP_BIT] = first_loop_bypass;
        end
        `VCP_ADDR_POLPUMP: begin
          next_rdata[`VCP_POL_BIT]     = tuning_polarity;
          next_rdata[`VCP_FORCE_BIT]   = force_midscale_tune;
          next_rdata[`VCP_CODE_MSB:0]  = first_pump_current_code;
        end
        `VCP_ADDR_OUTOFS: begin
          // Reads the staged values, not those in force
          next_rdata[`VCP_POWER_BIT]   = power_reg;
          next_rdata[`VCP_FORMAT_BIT]  = format_reg;
          next_rdata[`VCP_OFS_EN_BIT]  = phase_offset_enable;
          next_rdata[`VCP_CODE_MSB:0]  = phase_offset_code;
        end
        `VCP_ADDR_PUMP2: begin
          next_rdata[`VCP_AMP_MSB:`VCP_AMP_LSB] = amp_reg;
          next_rdata[`VCP_CODE_MSB:0]           = second_pump_current_code;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      feedback_chain_select       <= 1'b0;
      second_feedback_divider_msb <= 1'b0;
      first_loop_bypass           <= 1'b0;
      tuning_polarity             <= 1'b0;
      force_midscale_tune         <= `VCP_FORCE_RST;
      first_pump_current_code     <= `VCP_PUMP1_RST;
      power_reg                   <= 1'b0;
      format_reg                  <= 1'b0;
      phase_offset_enable         <= 1'b0;
      phase_offset_code           <= `VCP_OFS_RST;
      amp_reg                     <= 2'h0;
      second_pump_current_code    <= `VCP_PUMP2_RST;
      reg_rdata                   <= `VCP_BYTE_ZERO;
      reg_rvalid                  <= 1'b0;
    end else begin
      feedback_chain_select       <= next_fb_sel;
      second_feedback_divider_msb <= next_mv1_msb;
      first_loop_bypass           <= next_loop_byp;
      tuning_polarity             <= next_pol;
      force_midscale_tune         <= next_force;
      first_pump_current_code     <= next_pump1;
      power_reg                   <= next_power;
      format_reg                  <= next_format;
      phase_offset_enable         <= next_ofs_en;
      phase_offset_code           <= next_ofs;
      amp_reg                     <= next_amp;
      second_pump_current_code    <= next_pump2;
      reg_rdata                   <= next_rdata;
      reg_rvalid                  <= reg_rd;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  logic wr_fb;
  logic wr_loop;
  logic wr_pp;
  logic wr_oo;
  logic wr_p2;
  assign wr_fb   = reg_wr && (reg_addr == `VCP_ADDR_FB);
  assign wr_loop = reg_wr && (reg_addr == `VCP_ADDR_LOOP);
  assign wr_pp   = reg_wr && (reg_addr == `VCP_ADDR_POLPUMP);
  assign wr_oo   = reg_wr && (reg_addr == `VCP_ADDR_OUTOFS);
  assign wr_p2   = reg_wr && (reg_addr == `VCP_ADDR_PUMP2);

  property p_fb_sel;
    wr_fb ##1 !reg_wr[*2] |->
      feedback_chain_select == $past(reg_wdata[`VCP_FB_SEL_BIT], 2);
  endproperty
  a_fb_sel: assert property (p_fb_sel)
    else $error("feedback select not taken from write");

  property p_loop;
    wr_loop |=> first_loop_bypass == $past(reg_wdata[`VCP_LOOP_BYP_BIT]);
  endproperty
  a_loop: assert property (p_loop)
    else $error("loop bypass not taken from write");

  property p_pol;
    wr_pp |=> tuning_polarity == $past(reg_wdata[`VCP_POL_BIT])
      && force_midscale_tune == $past(reg_wdata[`VCP_FORCE_BIT]);
  endproperty
  a_pol: assert property (p_pol)
    else $error("polarity or force bit not taken from write");

  property p_force_rst;
    $rose(reset_n) |-> force_midscale_tune
      && first_pump_current_code == `VCP_PUMP1_RST;
  endproperty
  a_force_rst: assert property (p_force_rst)
    else $error("force bit or pump code wrong after reset");

  property p_pump1;
    wr_pp |=> first_pump_current_code == $past(reg_wdata[`VCP_CODE_MSB:0]);
  endproperty
  a_pump1: assert property (p_pump1)
    else $error("first pump code not taken from write");

  property p_out_hold;
    !out_link.commit |=> $stable(osc_output_power_on)
      && $stable(osc_output_format) && $stable(osc_output_amplitude);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("oscillator output changed without commit");

  property p_commit;
    out_link.commit |=> osc_output_power_on == $past(power_reg)
      && osc_output_format == $past(format_reg)
      && osc_output_amplitude == $past(amp_reg);
  endproperty
  a_commit: assert property (p_commit)
    else $error("commit did not apply staged output settings");

  property p_offset;
    wr_oo |=> phase_offset_code == $past(reg_wdata[`VCP_CODE_MSB:0])
      && phase_offset_enable == $past(reg_wdata[`VCP_OFS_EN_BIT]);
  endproperty
  a_offset: assert property (p_offset)
    else $error("offset fields not taken from write");

  property p_pump2;
    wr_p2 |=> second_pump_current_code == $past(reg_wdata[`VCP_CODE_MSB:0]);
  endproperty
  a_pump2: assert property (p_pump2)
    else $error("second pump code not taken from write");

  property p_reserved;
    reg_rd && reg_addr == `VCP_ADDR_LOOP |=> reg_rvalid
      && reg_rdata[7:1] == 7'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits read nonzero");

  c_commit: cover property (wr_oo ##[1:8] out_link.commit);
  c_unforce: cover property (wr_pp && !reg_wdata[`VCP_FORCE_BIT]);
  c_read: cover property (reg_rd ##1 reg_rvalid);

endmodule

// ===== verif/tb.sv
// Self-checking bench for the VCXO PLL control register bank.
// Assumes the rtl folder is on the include path; bank is driven directly.
`timescale 1ns/1ps
`include "vcp_defines.svh"
module tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic       core_clk;
  logic       reset_n;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       reg_rvalid;
  logic       fb_sel;
  logic       mv1_msb;
  logic       loop_byp;
  logic       polarity;
  logic       force_tune;
  logic [4:0] pump1;
  logic       ofs_en;
  logic [4:0] ofs_code;
  logic [4:0] pump2;
  logic       pwr_on;
  logic       fmt;
  logic [1:0] amp;
  // Reference copy of the bank and of the settings in force
  logic [7:0] m03, m0a, m10, m11, m12;
  logic [3:0] act;
  logic [7:0] exp_q[$];
  logic [7:0] addrs[8] = '{`VCP_ADDR_FB, `VCP_ADDR_LOOP, `VCP_ADDR_POLPUMP,
                           `VCP_ADDR_OUTOFS, `VCP_ADDR_PUMP2,
                           `VCP_ADDR_COMMIT, 8'h05, 8'hFF};
  integer     seed;
  integer     d;
  int         fails;
  int         tests_run;

  vcp_ctrl_regs DUT (
    .core_clk                    (core_clk),
    .reset_n                     (reset_n),
    .reg_addr                    (reg_addr),
    .reg_wdata                   (reg_wdata),
    .reg_wr                      (reg_wr),
    .reg_rd                      (reg_rd),
    .reg_rdata                   (reg_rdata),
    .reg_rvalid                  (reg_rvalid),
    .feedback_chain_select       (fb_sel),
    .second_feedback_divider_msb (mv1_msb),
    .first_loop_bypass           (loop_byp),
    .tuning_polarity             (polarity),
    .force_midscale_tune         (force_tune),
    .first_pump_current_code     (pump1),
    .phase_offset_enable         (ofs_en),
    .phase_offset_code           (ofs_code),
    .second_pump_current_code    (pump2),
    .osc_output_power_on         (pwr_on),
    .osc_output_format           (fmt),
    .osc_output_amplitude        (amp)
  );

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] seen,
                     input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("Checks run %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic model_reset();
    m03 = 8'h00;
    m0a = 8'h00;
    m10 = 8'h58;
    m11 = 8'h00;
    m12 = 8'h18;
    act = 4'hF;
  endtask

  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      `VCP_ADDR_FB:      return m03;
      `VCP_ADDR_LOOP:    return m0a;
      `VCP_ADDR_POLPUMP: return m10;
      `VCP_ADDR_OUTOFS:  return m11;
      `VCP_ADDR_PUMP2:   return m12;
      default:           return 8'h00;
    endcase
  endfunction

  // Sampled mid-cycle so the updates of the launching edge have landed
  task automatic check_fields();
    @(negedge core_clk);
    chk("fb_sel", 8'(fb_sel), 8'(m03[0]));
    chk("mv1_msb", 8'(mv1_msb), 8'(m03[7]));
    chk("loop_byp", 8'(loop_byp), 8'(m0a[0]));
    chk("polarity", 8'(polarity), 8'(m10[7]));
    chk("force_tune", 8'(force_tune), 8'(m10[6]));
    chk("pump1", 8'(pump1), 8'(m10[4:0]));
    chk("ofs_en", 8'(ofs_en), 8'(m11[5]));
    chk("ofs_code", 8'(ofs_code), 8'(m11[4:0]));
    chk("pump2", 8'(pump2), 8'(m12[4:0]));
    chk("pwr_on", 8'(pwr_on), 8'(act[3]));
    chk("fmt", 8'(fmt), 8'(act[2]));
    chk("amp", 8'(amp), 8'(act[1:0]));
  endtask

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    case (a)
      `VCP_ADDR_FB:      m03 = v & 8'h81;
      `VCP_ADDR_LOOP:    m0a = v & 8'h01;
      `VCP_ADDR_POLPUMP: m10 = v & 8'hDF;
      `VCP_ADDR_OUTOFS:  m11 = v;
      `VCP_ADDR_PUMP2:   m12 = v & 8'h7F;
      `VCP_ADDR_COMMIT:  act = {m11[7:6], m12[6:5]};
      default:           ;
    endcase
    check_fields();
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(exp_rd(a));
    @(posedge core_clk);
    reg_rd   <= 1'b0;
  endtask

  // Oldest expected read value is matched to each returned byte
  always @(posedge core_clk) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("unexpected read_data expected none seen %h", reg_rdata);
      end else begin
        chk("read_data", reg_rdata, exp_q.pop_front());
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Whole run needs roughly 350 cycles; generous margin
  initial begin
    repeat (8000) @(posedge core_clk);
    fails++;
    give_verdict();
  end

  initial begin
    reset_n   = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    seed      = 32'h0000_3923;
    fails     = 0;
    tests_run = 0;
    model_reset();
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    check_fields();
    foreach (addrs[i]) rd(addrs[i]);
    // Software releases the forced tuning so the loop can lock
    wr(`VCP_ADDR_POLPUMP, 8'h18);
    // Every power and format pairing, staged first, applied on commit
    // Offset code 0x15 stands above the jitter figure times 400
    for (int k = 0; k < 4; k++) begin
      wr(`VCP_ADDR_OUTOFS, {k[1:0], 6'h35});
      wr(`VCP_ADDR_PUMP2, {1'b0, ~k[1:0], 5'h1F});
      rd(`VCP_ADDR_OUTOFS);
      wr(`VCP_ADDR_COMMIT, 8'hA5);
    end
    // Random bytes everywhere, reserved bits and unmapped places included
    for (int n = 0; n < 8; n++) begin
      foreach (addrs[i]) begin
        d = $random(seed);
        wr(addrs[i], d[7:0]);
        rd(addrs[i]);
      end
    end
    // Reset in mid-run brings back startup values
    @(posedge core_clk);
    reset_n <= 1'b0;
    model_reset();
    check_fields();
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    foreach (addrs[i]) rd(addrs[i]);
    repeat (3) @(posedge core_clk);
    chk("pending_reads", 8'(exp_q.size()), 8'h00);
    give_verdict();
  end
endmodule
